// ---- core/xosc_pkg.sv ----
// constants and types of the crystal oscillator clock gating block
//
// Notes on behaviour
// [RQ1] control bit 7 gates peripheral reference clock
// [RQ2] bit 5 keeps peripheral clock through stop
// [RQ3] bits 6 and 4 read zero always
// [RQ4] bits 3..0 select 2/4/8/16 pF loads
// [RQ5] eight-bit read-write control, resets to zero
// [RQ6] software keeps range settings while oscillator runs
// [RQ7] system clock in run mode only
// [RQ8] bypass forwards input pin clock directly
// [RQ9] drive pin released to GPIO in bypass
// [RQ10] output off until 4096 raw cycles seen
// [RQ11] startup counter cleared while not generating
// [RQ12] registers keep through stop, reset on deep wake
// [RQ13] gate switches only while source is low
package xosc_pkg;

  localparam int unsigned APB_AW         = 12;
  localparam int unsigned APB_DW         = 32;

  localparam logic [11:0] OFFS_CTRL      = 12'h000;
  localparam logic [11:0] OFFS_CFG       = 12'h004;
  localparam logic [11:0] OFFS_STAT      = 12'h008;

  localparam int unsigned CTRL_W         = 8;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam logic [7:0]  CTRL_WMASK     = 8'haf;
  localparam int unsigned CTRL_PERIPH_EN = 7;
  localparam int unsigned CTRL_STOP_KEEP = 5;
  localparam int unsigned CTRL_CAP2      = 3;
  localparam int unsigned CTRL_CAP4      = 2;
  localparam int unsigned CTRL_CAP8      = 1;
  localparam int unsigned CTRL_CAP16     = 0;

  localparam int unsigned CFG_W          = 3;
  localparam logic [2:0]  CFG_RESET      = 3'h0;
  localparam int unsigned CFG_OSC_EN     = 0;
  localparam int unsigned CFG_CRYSTAL    = 1;
  localparam int unsigned CFG_SLOW_EN    = 2;

  localparam int unsigned STAT_W         = 6;
  localparam int unsigned STAT_DONE      = 4;
  localparam int unsigned STAT_PERIPH    = 5;

  localparam int unsigned STARTUP_CNT_W  = 13;
  localparam logic [12:0] STARTUP_CYCLES = 13'h1000;

  localparam int unsigned PIN_W          = 2;
  localparam int unsigned PIN_INPUT      = 0;
  localparam int unsigned PIN_DRIVE      = 1;

  localparam int unsigned NUM_GATES      = 3;
  localparam int unsigned GATE_SYS       = 0;
  localparam int unsigned GATE_PERIPH    = 1;
  localparam int unsigned GATE_SLOW      = 2;

  typedef enum logic [3:0] {
    ST_OFF     = 4'h1,
    ST_STARTUP = 4'h2,
    ST_STABLE  = 4'h4,
    ST_EXTCLK  = 4'h8
  } xosc_state_e;

endpackage : xosc_pkg

// ---- core/xosc_startup_counter.sv ----
// startup counter that qualifies the raw oscillation
`timescale 1ns/1ps
module xosc_startup_counter (
  input  wire logic sys_clk,
  input  wire logic resetn,
  input  wire logic countClear,
  input  wire logic rawEdge,
  output logic      startupCountDone
);
  import xosc_pkg::*;

  logic [STARTUP_CNT_W-1:0] count_r;
  logic [STARTUP_CNT_W-1:0] count_nxt;
  logic                     done_r;
  logic                     lastEdge;

  assign count_nxt = count_r + 13'h0001;
  assign lastEdge  = rawEdge && (count_nxt == STARTUP_CYCLES);

  always_ff @(posedge sys_clk) begin
    if (!resetn || countClear) begin // RQ11
      count_r <= '0;
      done_r  <= 1'b0;
    end else if (rawEdge && !done_r) begin
      count_r <= count_nxt;
      done_r  <= lastEdge; // RQ10
    end
  end

  assign startupCountDone = done_r;

endmodule : xosc_startup_counter

// ---- core/xosc_clk_gate.sv ----
// glitch-free gate cell for one clock output
`timescale 1ns/1ps
module xosc_clk_gate (
  input  wire logic sys_clk,
  input  wire logic resetn,
  input  wire logic srcClk,
  input  wire logic enableReq,
  output logic      gateOn,
  output logic      clkOut
);
  logic gateOn_r;
  logic clkOut_r;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      gateOn_r <= 1'b0;
    end else if (!srcClk) begin
      gateOn_r <= enableReq; // RQ13
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      clkOut_r <= 1'b0;
    end else begin
      clkOut_r <= srcClk & gateOn_r;
    end
  end

  assign gateOn = gateOn_r;
  assign clkOut = clkOut_r;

endmodule : xosc_clk_gate

// ---- core/xosc_clock_gating.sv ----
// crystal oscillator control, clock gating and register slave
`timescale 1ns/1ps
module xosc_clock_gating (
  input  wire logic                       sys_clk,
  input  wire logic                       resetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [xosc_pkg::APB_AW-1:0] paddr,
  input  wire logic [xosc_pkg::APB_DW-1:0] pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic      [xosc_pkg::APB_DW-1:0] prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       stopMode,
  input  wire logic                       veryLowLeakageWake,
  input  wire logic                       gpioAltSel,
  input  wire logic                       gpioOut,
  input  wire logic                       gpioOe,
  output logic                            gpioIn,
  input  wire logic                       oscInputPin,
  input  wire logic                       oscDrivePinIn,
  output logic                            oscDrivePinOut,
  output logic                            oscDrivePinOe,
  output logic                            oscSystemClk,
  output logic                            oscPeriphRefClk,
  output logic                            oscSlow32kClk,
  output logic                            startupCountDone,
  output logic                            loadCap2pfSel,
  output logic                            loadCap4pfSel,
  output logic                            loadCap8pfSel,
  output logic                            loadCap16pfSel
);
  import xosc_pkg::*;

  // word address match, shared by read and write decode
  function automatic logic isReg(input logic [APB_AW-1:0] addr,
                                 input logic [11:0]       offs);
    isReg = (addr[APB_AW-1:2] == offs[APB_AW-1:2]);
  endfunction : isReg

  // register bus
  logic [APB_DW-1:0] prdata_r;
  logic              pready_r;
  logic              pslverr_r;
  logic              accessPhase;
  logic              commit;
  logic              hitCtrl;
  logic              hitCfg;
  logic              hitStat;
  logic              mapped;
  logic              wrCtrl;
  logic              wrCfg;
  logic [APB_DW-1:0] rdataMux;

  // software state
  logic [CTRL_W-1:0] ctrl_r;
  logic [CTRL_W-1:0] ctrl_nxt;
  logic [CFG_W-1:0]  cfg_r;
  logic [CFG_W-1:0]  cfg_nxt;
  logic [STAT_W-1:0] status;
  logic              regClear;

  // pin inputs
  logic [PIN_W-1:0]  pinSync1_r;
  logic [PIN_W-1:0]  pinSync2_r;
  logic [PIN_W-1:0]  pinSync3_r;
  logic [PIN_W-1:0]  pinLevel_r;
  logic [PIN_W-1:0]  pinLevel_nxt;
  logic [PIN_W-1:0]  pinAgree;
  logic              rawOscClk;
  logic              rawPrev_r;
  logic              rawEdge;

  // oscillator state
  xosc_state_e       state_r;
  xosc_state_e       state_nxt;
  logic              oscEnable;
  logic              crystalSel;
  logic              generating;
  logic              clkRunning;
  logic              countDone;

  // stop handling
  logic              stopPrev_r;
  logic              keepArmed_r;
  logic              stopEntry;

  // gates
  logic [NUM_GATES-1:0] gateWant;
  logic [NUM_GATES-1:0] gateOn;
  logic [NUM_GATES-1:0] gateClk;

  // drive pin
  logic              drivePinOut_r;
  logic              drivePinOe_r;
  logic              drivePinOut_nxt;
  logic              drivePinOe_nxt;
  logic              pinReleased;

  // ------------------------------------------------------------------
  // register slave: setup, one wait cycle, then pready for one cycle
  assign accessPhase = psel & penable;
  assign commit      = accessPhase & pready_r;
  assign hitCtrl     = isReg(paddr, OFFS_CTRL);
  assign hitCfg      = isReg(paddr, OFFS_CFG);
  assign hitStat     = isReg(paddr, OFFS_STAT);
  assign mapped      = hitCtrl | hitCfg | hitStat;
  assign wrCtrl      = commit & pwrite & hitCtrl & pstrb[0];
  assign wrCfg       = commit & pwrite & hitCfg & pstrb[0];

  assign rdataMux = hitCtrl ? {24'h000000, ctrl_r} :
                    hitCfg  ? {29'h00000000, cfg_r} :
                    hitStat ? {26'h0000000, status} :
                              32'h00000000;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= accessPhase & ~pready_r;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      prdata_r  <= '0;
      pslverr_r <= 1'b0;
    end else if (accessPhase && !pready_r) begin
      prdata_r  <= pwrite ? 32'h00000000 : rdataMux;
      pslverr_r <= ~mapped;
    end else begin
      prdata_r  <= '0;
      pslverr_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // control and configuration registers
  assign regClear = ~resetn | veryLowLeakageWake; // RQ12
  assign ctrl_nxt = pwdata[CTRL_W-1:0] & CTRL_WMASK; // RQ3
  assign cfg_nxt  = pwdata[CFG_W-1:0];

  always_ff @(posedge sys_clk) begin
    if (regClear) begin
      ctrl_r <= CTRL_RESET; // RQ5
    end else if (wrCtrl) begin
      ctrl_r <= ctrl_nxt; // RQ5
    end
  end

  always_ff @(posedge sys_clk) begin
    if (regClear) begin
      cfg_r <= CFG_RESET;
    end else if (wrCfg) begin
      cfg_r <= cfg_nxt;
    end
  end

  assign oscEnable  = cfg_r[CFG_OSC_EN];
  assign crystalSel = cfg_r[CFG_CRYSTAL];
  assign generating = oscEnable & crystalSel;

  assign status = {gateOn[GATE_PERIPH], countDone, state_r};

  // ------------------------------------------------------------------
  // pin synchronisers: a change counts once stages two and three agree
  assign pinAgree     = ~(pinSync2_r ^ pinSync3_r);
  assign pinLevel_nxt = (pinAgree & pinSync3_r) | (~pinAgree & pinLevel_r);

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pinSync1_r <= '0;
      pinSync2_r <= '0;
      pinSync3_r <= '0;
      pinLevel_r <= '0;
    end else begin
      pinSync1_r <= {oscDrivePinIn, oscInputPin};
      pinSync2_r <= pinSync1_r;
      pinSync3_r <= pinSync2_r;
      pinLevel_r <= pinLevel_nxt;
    end
  end

  assign rawOscClk = pinLevel_r[PIN_INPUT];
  assign rawEdge   = rawOscClk & ~rawPrev_r;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rawPrev_r <= 1'b0;
    end else begin
      rawPrev_r <= rawOscClk;
    end
  end

  xosc_startup_counter uStartup (
    .sys_clk          (sys_clk),
    .resetn           (resetn),
    .countClear       (~generating), // RQ11
    .rawEdge          (rawEdge),
    .startupCountDone (countDone)
  );

  // ------------------------------------------------------------------
  // oscillator state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_OFF: begin
        if (oscEnable) begin
          state_nxt = crystalSel ? ST_STARTUP : ST_EXTCLK;
        end
      end
      ST_STARTUP: begin
        if (!oscEnable) begin
          state_nxt = ST_OFF;
        end else if (!crystalSel) begin
          state_nxt = ST_EXTCLK;
        end else if (countDone) begin
          state_nxt = ST_STABLE; // RQ10
        end
      end
      ST_STABLE: begin
        if (!oscEnable) begin
          state_nxt = ST_OFF;
        end else if (!crystalSel) begin
          state_nxt = ST_EXTCLK;
        end
      end
      ST_EXTCLK: begin
        if (!oscEnable) begin
          state_nxt = ST_OFF;
        end else if (crystalSel) begin
          state_nxt = ST_STARTUP;
        end
      end
      default: begin
        state_nxt = ST_OFF;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_r <= ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // bypass passes the pin clock with no startup wait
  assign clkRunning = (state_r == ST_STABLE) | (state_r == ST_EXTCLK); // RQ8

  // ------------------------------------------------------------------
  // stop entry captures whether the peripheral clock enable bit 7 was set
  assign stopEntry = stopMode & ~stopPrev_r;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      stopPrev_r  <= 1'b0;
      keepArmed_r <= 1'b0;
    end else begin
      stopPrev_r <= stopMode;
      if (stopEntry) begin
        keepArmed_r <= ctrl_r[CTRL_PERIPH_EN]; // RQ2
      end else if (!stopMode) begin
        keepArmed_r <= 1'b0;
      end
    end
  end

  assign gateWant[GATE_SYS]    = clkRunning & ~stopMode; // RQ7
  assign gateWant[GATE_PERIPH] = clkRunning & ctrl_r[CTRL_PERIPH_EN] & // RQ1
                                 (~stopMode | // RQ7
                                  (ctrl_r[CTRL_STOP_KEEP] & keepArmed_r));
  assign gateWant[GATE_SLOW]   = clkRunning & cfg_r[CFG_SLOW_EN]; // RQ7

  generate
    for (genvar g = 0; g < NUM_GATES; g++) begin : gGate
      xosc_clk_gate uGate (
        .sys_clk   (sys_clk),
        .resetn    (resetn),
        .srcClk    (rawOscClk),
        .enableReq (gateWant[g]),
        .gateOn    (gateOn[g]),
        .clkOut    (gateClk[g])
      );
    end
  endgenerate

  // ------------------------------------------------------------------
  // drive pin: amplifier output while generating, else GPIO or idle
  assign pinReleased = (state_r == ST_EXTCLK) & gpioAltSel; // RQ9

  assign drivePinOut_nxt = generating  ? ~rawOscClk :
                           pinReleased ? gpioOut    : 1'b0;
  assign drivePinOe_nxt  = generating | (pinReleased & gpioOe);

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      drivePinOut_r <= 1'b0;
      drivePinOe_r  <= 1'b0;
    end else begin
      drivePinOut_r <= drivePinOut_nxt;
      drivePinOe_r  <= drivePinOe_nxt;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  assign prdata           = prdata_r;
  assign pready           = pready_r;
  assign pslverr          = pslverr_r;
  assign gpioIn           = pinLevel_r[PIN_DRIVE];
  assign oscDrivePinOut   = drivePinOut_r;
  assign oscDrivePinOe    = drivePinOe_r;
  assign oscSystemClk     = gateClk[GATE_SYS];
  assign oscPeriphRefClk  = gateClk[GATE_PERIPH];
  assign oscSlow32kClk    = gateClk[GATE_SLOW];
  assign startupCountDone = countDone;
  assign loadCap2pfSel    = ctrl_r[CTRL_CAP2]; // RQ4
  assign loadCap4pfSel    = ctrl_r[CTRL_CAP4]; // RQ4
  assign loadCap8pfSel    = ctrl_r[CTRL_CAP8]; // RQ4
  assign loadCap16pfSel   = ctrl_r[CTRL_CAP16]; // RQ4

endmodule : xosc_clock_gating

// ---- testbench/xosc_clock_gating_monitor.sv ----
// assertion checker for the oscillator clock gating block
`timescale 1ns/1ps
module xosc_clock_gating_monitor (
  input wire logic                        sys_clk,
  input wire logic                        resetn,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [xosc_pkg::APB_AW-1:0] paddr,
  input wire logic [xosc_pkg::APB_DW-1:0] pwdata,
  input wire logic [3:0]                  pstrb,
  input wire logic [xosc_pkg::APB_DW-1:0] prdata,
  input wire logic                        pready,
  input wire logic                        pslverr,
  input wire logic                        stopMode,
  input wire logic                        veryLowLeakageWake,
  input wire logic                        gpioAltSel,
  input wire logic                        oscDrivePinOe,
  input wire logic                        oscSystemClk,
  input wire logic                        startupCountDone,
  input wire logic                        loadCap2pfSel,
  input wire logic                        loadCap4pfSel,
  input wire logic                        loadCap8pfSel,
  input wire logic                        loadCap16pfSel
);
  import xosc_pkg::*;
  wire       ctrlAt = paddr[11:2] == 10'h000;
  wire       ctrlWr = psel && penable && pready && pwrite && pstrb[0] && ctrlAt;
  wire [3:0] caps   = {loadCap2pfSel, loadCap4pfSel, loadCap8pfSel,
                       loadCap16pfSel};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  a_rsvd_read_zero: assert property (
    pready && !pwrite && ctrlAt |-> prdata[31:8] == 24'h0 && !prdata[6]
    && !prdata[4]) else $error("reserved control bits read nonzero");
  a_cap_follow_write: assert property (
    ctrlWr && !veryLowLeakageWake |=> caps == $past(pwdata[3:0]))
    else $error("load select differs from written value");
  a_cap_hold_idle: assert property (
    $changed(caps) |-> $past(ctrlWr) || $past(veryLowLeakageWake))
    else $error("load select changed without a write");
  a_wake_clears_ctrl: assert property (
    veryLowLeakageWake |=> caps == 4'h0) else $error("wake kept control");
  a_sys_off_stop: assert property (
    stopMode [*6] |-> !$rose(oscSystemClk))
    else $error("system clock edge during stop");
  a_startup_gated: assert property (
    (oscDrivePinOe && !gpioAltSel && !startupCountDone) [*4]
    |-> !$rose(oscSystemClk)) else $error("clock before startup done");
  a_done_cleared: assert property (
    (!oscDrivePinOe) [*3] |-> !startupCountDone)
    else $error("startup done held while not generating");
  a_one_wait: assert property (
    psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("ready not after one wait state");
  a_unmapped_err: assert property (
    pready && paddr[11:2] > 10'h002 |-> pslverr)
    else $error("unmapped access without error");
endmodule : xosc_clock_gating_monitor

bind xosc_clock_gating xosc_clock_gating_monitor uMon (
  .sys_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
  .prdata, .pready, .pslverr, .stopMode, .veryLowLeakageWake, .gpioAltSel,
  .oscDrivePinOe, .oscSystemClk, .startupCountDone, .loadCap2pfSel,
  .loadCap4pfSel, .loadCap8pfSel, .loadCap16pfSel);

// ---- testbench/xosc_source_model.sv ----
// crystal or external clock source at the oscillator pins
`timescale 1ns/1ps
module xosc_source_model #(
  parameter int HALF = 8
) (
  input  wire logic sys_clk,
  input  wire logic run,
  input  wire logic drivePinOut,
  input  wire logic drivePinOe,
  output logic      oscInputPin,
  output logic      drivePinLevel
);
  int   cnt = 0;
  logic lastDriven = 1'b0;
  initial oscInputPin = 1'b0;
  always @(posedge sys_clk) begin
    if (drivePinOe) begin
      lastDriven <= drivePinOut;
    end
    if (!run) begin
      cnt <= 0;
      oscInputPin <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      oscInputPin <= ~oscInputPin;
    end else begin
      cnt <= cnt + 1;
    end
  end
  // no pull on the drive pin: released shows the inverse of its last level
  assign drivePinLevel = drivePinOe ? drivePinOut : ~lastDriven;
endmodule : xosc_source_model

// ---- testbench/xosc_clock_gating_tb.sv ----
// self-checking testbench for the oscillator clock gating block
`timescale 1ns/1ps
module xosc_clock_gating_tb;
  import xosc_pkg::*;
  logic        sys_clk, resetn, psel, penable, pwrite, stopMode, srcRun;
  logic        veryLowLeakageWake, gpioAltSel, gpioOut, gpioOe, pready;
  logic        pslverr, oscInputPin, oscDrivePinIn, oscDrivePinOut;
  logic        oscDrivePinOe, startupCountDone, oscSystemClk, gpioIn;
  logic        oscPeriphRefClk, oscSlow32kClk, loadCap2pfSel;
  logic        loadCap4pfSel, loadCap8pfSel, loadCap16pfSel;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, v;
  logic [3:0]  pstrb;
  logic [2:0]  on;
  logic [33:0] expQ[$];
  int          errTotal = 0, samplesChecked = 0, rawCnt = 0, n;
  wire  [2:0]  clks = {oscSlow32kClk, oscPeriphRefClk, oscSystemClk};
  wire  [3:0]  caps = {loadCap2pfSel, loadCap4pfSel, loadCap8pfSel,
                       loadCap16pfSel};
  xosc_clock_gating uut (
    .sys_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .stopMode, .veryLowLeakageWake, .gpioAltSel,
    .gpioOut, .gpioOe, .gpioIn, .oscInputPin, .oscDrivePinIn,
    .oscDrivePinOut, .oscDrivePinOe, .oscSystemClk, .oscPeriphRefClk,
    .oscSlow32kClk, .startupCountDone, .loadCap2pfSel, .loadCap4pfSel,
    .loadCap8pfSel, .loadCap16pfSel);
  xosc_source_model #(.HALF(8)) src (.sys_clk, .run(srcRun),
    .drivePinOut(oscDrivePinOut), .drivePinOe(oscDrivePinOe),
    .oscInputPin, .drivePinLevel(oscDrivePinIn));
  initial sys_clk = 1'b0;
  always #2 sys_clk = ~sys_clk;
  always @(posedge oscInputPin) rawCnt = rawCnt + 1;
  task automatic test_done;
    $display("checks %0d mismatches %0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done
  task automatic cmpVal(input logic [31:0] g, e, input string w);
    samplesChecked++;
    if (g !== e) begin
      errTotal++;
      $display("[FAIL] %0t %s got %h exp %h", $time, w, g, e);
    end
  endtask : cmpVal
  task automatic cmpRead(input logic [33:0] x);
    samplesChecked++;
    if (pslverr !== x[32] || (x[33] && prdata !== x[31:0])) begin
      errTotal++;
      $display("[FAIL] %0t apb got %h %b exp %h", $time, prdata, pslverr, x);
    end
  endtask : cmpRead
  // expected bus answer noted first, checked by the watcher below
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input logic err);
    expQ.push_back({~wr, err, d});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge so the next call never re-drives psel in this step
    @(posedge sys_clk);
  endtask : apb
  always @(posedge sys_clk) begin
    if (psel && penable && pready === 1'b1 && expQ.size() > 0) begin
      cmpRead(expQ.pop_front());
    end
  end
  // rising edges of each clock output after settling
  task automatic act(output logic [2:0] r);
    logic [2:0] p;
    repeat (24) @(posedge sys_clk);
    r = 3'b000;
    p = clks;
    repeat (80) begin
      @(posedge sys_clk);
      r = r | (clks & ~p);
      p = clks;
    end
  endtask : act
  initial begin
    {psel, penable, pwrite, stopMode, srcRun, veryLowLeakageWake} = '0;
    {gpioAltSel, gpioOut, gpioOe, resetn} = '0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hf;
    v = $urandom(97404);
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0, 1'b0);
    apb(1'b0, 12'h00c, 32'h0, 1'b1);
    repeat (6) begin
      v = $urandom;
      apb(1'b1, 12'h000, v, 1'b0);
      apb(1'b0, 12'h000, v & 32'haf, 1'b0);
      cmpVal(32'(caps), 32'(v[3:0]), "caps");
    end
    $display("register test done");
    srcRun <= 1'b1;
    apb(1'b1, 12'h004, 32'h5, 1'b0);
    apb(1'b1, 12'h000, 32'h80, 1'b0);
    act(on);
    cmpVal(32'(on), 32'h7, "bypass");
    gpioAltSel <= 1'b1;
    gpioOe <= 1'b1;
    gpioOut <= v[0];
    repeat (3) @(posedge sys_clk);
    cmpVal(32'({oscDrivePinOe, oscDrivePinOut}), 32'({1'b1, v[0]}),
           "gpio");
    repeat (6) @(posedge sys_clk);
    cmpVal(32'(gpioIn), 32'(v[0]), "gpio in");
    apb(1'b1, 12'h000, 32'h0, 1'b0);
    act(on);
    cmpVal(32'(on), 32'h5, "periph off");
    apb(1'b1, 12'h000, 32'h80, 1'b0);
    stopMode <= 1'b1;
    act(on);
    cmpVal(32'(on), 32'h4, "stop");
    stopMode <= 1'b0;
    apb(1'b1, 12'h000, 32'ha0, 1'b0);
    stopMode <= 1'b1;
    act(on);
    cmpVal(32'(on), 32'h6, "keep");
    stopMode <= 1'b0;
    apb(1'b1, 12'h000, 32'h20, 1'b0);
    stopMode <= 1'b1;
    apb(1'b1, 12'h000, 32'ha0, 1'b0);
    act(on);
    cmpVal(32'(on), 32'h4, "late enable");
    apb(1'b0, 12'h000, 32'ha0, 1'b0);
    stopMode <= 1'b0;
    veryLowLeakageWake <= 1'b1;
    @(posedge sys_clk);
    veryLowLeakageWake <= 1'b0;
    apb(1'b0, 12'h000, 32'h0, 1'b0);
    $display("clock gating test done");
    gpioAltSel <= 1'b0;
    srcRun <= 1'b0;
    // oscillator disabled before its mode changes
    apb(1'b1, 12'h004, 32'h0, 1'b0);
    apb(1'b1, 12'h004, 32'h3, 1'b0);
    rawCnt = 0;
    srcRun <= 1'b1;
    wait (rawCnt == 4090);
    cmpVal(32'(startupCountDone), 32'h0, "early done");
    n = 0;
    while (startupCountDone !== 1'b1 && n < 400) begin
      @(posedge sys_clk);
      n++;
    end
    cmpVal(32'(rawCnt >= 4096 && rawCnt <= 4097), 32'h1, "count");
    act(on);
    cmpVal(32'(on), 32'h1, "stable");
    apb(1'b1, 12'h004, 32'h0, 1'b0);
    apb(1'b1, 12'h004, 32'h3, 1'b0);
    repeat (4) @(posedge sys_clk);
    cmpVal(32'(startupCountDone), 32'h0, "restart");
    $display("startup test done");
    test_done();
  end
  initial begin
    #400000;
    errTotal++;
    $display("[FAIL] %0t watchdog expired", $time);
    test_done();
  end
endmodule : xosc_clock_gating_tb
